/* hdl/ppol_top.sv */
`timescale 1ns/1ns

// Summary of operation
// - digital input clamped low while sleep clamp is asserted
// - enabled external interrupt pins bypass the clamp
// - clamp release edge sets external interrupt flag even if disabled
// - pull-up from override if enabled, else dir/out/disable = 010
// - active pull-up override ignores direction, output and disable
// - driver enable from direction override if enabled, else direction
// - active direction override sets driver whatever the direction bit
// - level from value override if enabled, else from output bit
// - active value override sets level whatever the output bit
// - toggle override inverts the output bit
// - input enable from override if enabled, else normal versus clamp
// - active input enable override ignores sleep state
// - alternate functions other than the test port and the analog path get the clamped input, registered once, and synchronise it
// - analog path taken straight from the pad
// - port A pins 7..4 are external interrupts 3..0, input override only
// - port A pins 4..0 feed converter channels; low pins no overrides
// - port B pin 7 carries timer 0 compare B if direction is output
// - port B pin 6 carries timer 0 compare A if direction is output
// - pins feed pin change sources; A to 7..0, B to 15..8
// - port B pins 3..0 are test clock, mode select, data in, data out
// - enabled test port takes over port B pins 3..0
// - without overrides direction one is output, zero is input
module ppol_top (
    input  wire logic        clk_in,               // i/o clock
    input  wire logic        rst_b_in,             // async reset, active low
    input  wire logic        psel_in,              // apb select
    input  wire logic        penable_in,           // apb enable
    input  wire logic        pwrite_in,            // apb direction
    input  wire logic [7:0]  paddr_in,             // apb byte address
    input  wire logic [31:0] pwdata_in,            // apb write data
    output logic      [31:0] prdata_out,           // apb read data
    output logic             pready_out,           // apb ready
    output logic             pslverr_out,          // apb error
    input  wire logic [15:0] pad_in,               // pad levels
    output logic      [15:0] pad_out,              // pad drive level
    output logic      [15:0] pad_oe_out,           // pad driver enable
    output logic      [15:0] pad_pullup_out,       // pad pull-up enable
    input  wire logic        sleep_clamp_in,       // sleep clamp request
    input  wire logic [15:0] pin_toggle_override_enable_in, // toggle
    input  wire logic        timer0_compare_out_a_in,    // compare a
    input  wire logic        timer0_compare_a_en_in,     // compare a on
    input  wire logic        timer0_compare_out_b_in,    // compare b
    input  wire logic        timer0_compare_b_en_in,     // compare b on
    input  wire logic        test_port_enabled_in,       // test port on
    input  wire logic        test_data_out_in,           // test data out
    input  wire logic        test_shift_in,              // shifting ir/dr
    output logic      [15:0] pin_change_irq_sources_out, // pin change
    output logic      [3:0]  external_irq_inputs_out,    // ext irq inputs
    output logic      [3:0]  ext_irq_flag_out,           // ext irq flags
    output logic      [4:0]  alt_function_analog_path_out, // converter
    output logic      [2:0]  test_port_in_out     // tck, tms, tdi
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] pin_output_bit_reg;
    logic [15:0] pin_direction_bit_reg;
    logic        global_pullup_disable_reg;
    logic [3:0]  ext_irq_enable_reg;
    logic [7:0]  ext_irq_sense_reg;
    logic [3:0]  ext_irq_flag_reg;
    logic [15:0] digital_in_reg;
    logic [3:0]  ext_in_prev_reg;

    // ************************************************************
    // override vectors
    // ************************************************************
    logic [15:0] pullup_override_enable;
    logic [15:0] pullup_override_value;
    logic [15:0] direction_override_enable;
    logic [15:0] direction_override_value;
    logic [15:0] pin_value_override_enable;
    logic [15:0] pin_value_override_value;
    logic [15:0] input_enable_override_enable;
    logic [15:0] input_enable_override_value;
    logic [15:0] pullup_next;
    logic [15:0] oe_next;
    logic [15:0] level_next;
    logic [15:0] input_enable;
    logic [15:0] alt_function_digital_in;

    always_comb begin
        pullup_override_enable       = 16'h0000;
        pullup_override_value        = 16'h0000;
        direction_override_enable    = 16'h0000;
        direction_override_value     = 16'h0000;
        pin_value_override_enable    = 16'h0000;
        pin_value_override_value     = 16'h0000;
        input_enable_override_enable = 16'h0000;
        input_enable_override_value  = 16'h0000;
        // external interrupt pins only override input enable
        input_enable_override_enable[ppol_pkg::EXT_IRQ_PIN_LO +:
            ppol_pkg::EXT_IRQ_COUNT] = ext_irq_enable_reg;
        input_enable_override_value[ppol_pkg::EXT_IRQ_PIN_LO +:
            ppol_pkg::EXT_IRQ_COUNT] = ext_irq_enable_reg;
        // timer compare outputs take the level, not the direction
        pin_value_override_enable[ppol_pkg::OC_B_PIN] =
            timer0_compare_b_en_in;
        pin_value_override_value[ppol_pkg::OC_B_PIN] =
            timer0_compare_out_b_in;
        pin_value_override_enable[ppol_pkg::OC_A_PIN] =
            timer0_compare_a_en_in;
        pin_value_override_value[ppol_pkg::OC_A_PIN] =
            timer0_compare_out_a_in;
        // test port claims port b pins 3..0
        pullup_override_enable[ppol_pkg::TEST_PIN_LO +:
            ppol_pkg::TEST_PIN_COUNT] = {4{test_port_enabled_in}};
        pullup_override_value[ppol_pkg::TEST_PIN_LO +:
            ppol_pkg::TEST_PIN_COUNT] = ppol_pkg::TEST_PULLUP_VALUE;
        direction_override_enable[ppol_pkg::TEST_PIN_LO +:
            ppol_pkg::TEST_PIN_COUNT] = {4{test_port_enabled_in}};
        direction_override_value[ppol_pkg::TEST_PIN_LO] = test_shift_in;
        pin_value_override_enable[ppol_pkg::TEST_PIN_LO] =
            test_port_enabled_in;
        pin_value_override_value[ppol_pkg::TEST_PIN_LO] = test_data_out_in;
        input_enable_override_enable[ppol_pkg::TEST_PIN_LO +:
            ppol_pkg::TEST_PIN_COUNT] = {4{test_port_enabled_in}};
    end

    // ************************************************************
    // per-pin control path
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < ppol_pkg::PIN_COUNT; gi++) begin : g_pin
            assign pullup_next[gi] = pullup_override_enable[gi] ?
                pullup_override_value[gi] :
                (~pin_direction_bit_reg[gi] & pin_output_bit_reg[gi] &
                 ~global_pullup_disable_reg);
            assign oe_next[gi] = direction_override_enable[gi] ?
                direction_override_value[gi] :
                pin_direction_bit_reg[gi];
            assign level_next[gi] = pin_value_override_enable[gi] ?
                pin_value_override_value[gi] :
                pin_output_bit_reg[gi];
            assign input_enable[gi] = input_enable_override_enable[gi] ?
                input_enable_override_value[gi] :
                ~sleep_clamp_in;
            // clamp to ground ahead of the schmitt trigger
            assign alt_function_digital_in[gi] =
                pad_in[gi] & input_enable[gi];
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pad_out        <= 16'h0000;
            pad_oe_out     <= 16'h0000;
            pad_pullup_out <= 16'h0000;
        end else begin
            pad_out        <= level_next;
            pad_oe_out     <= oe_next;
            pad_pullup_out <= pullup_next;
        end
    end

    // ************************************************************
    // inputs toward alternate functions
    // ************************************************************
    // one register stage only; receivers still synchronise
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            digital_in_reg <= 16'h0000;
        end else begin
            digital_in_reg <= alt_function_digital_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_change_irq_sources_out   <= 16'h0000;
            external_irq_inputs_out      <= 4'h0;
            alt_function_analog_path_out <= 5'h00;
            test_port_in_out             <= 3'h0;
        end else begin
            pin_change_irq_sources_out <= alt_function_digital_in;
            external_irq_inputs_out <=
                alt_function_digital_in[ppol_pkg::EXT_IRQ_PIN_LO +:
                    ppol_pkg::EXT_IRQ_COUNT];
            // raw pad sample, no input enable or clamp
            alt_function_analog_path_out <=
                pad_in[ppol_pkg::ANALOG_COUNT-1:0];
            // test inputs bypass the disabled digital input
            test_port_in_out <= pad_in[ppol_pkg::TEST_PIN_LO + 1 +: 3];
        end
    end

    // ************************************************************
    // external interrupt edge flags
    // ************************************************************
    logic [3:0] ext_now;
    logic [3:0] ext_edge_set;

    assign ext_now = alt_function_digital_in[ppol_pkg::EXT_IRQ_PIN_LO +:
        ppol_pkg::EXT_IRQ_COUNT];

    // edges are seen whether or not the request is enabled, so a clamp
    // release on a high pin raises the flag on wake
    generate
        for (gi = 0; gi < ppol_pkg::EXT_IRQ_COUNT; gi++) begin : g_irq
            logic [1:0] sense;
            assign sense = ext_irq_sense_reg[2*gi +: 2];
            assign ext_edge_set[gi] =
                ((sense == ppol_pkg::SENSE_ANY_EDGE) &&
                 (ext_now[gi] != ext_in_prev_reg[gi])) ||
                ((sense == ppol_pkg::SENSE_FALLING) &&
                 !ext_now[gi] && ext_in_prev_reg[gi]) ||
                ((sense == ppol_pkg::SENSE_RISING) &&
                 ext_now[gi] && !ext_in_prev_reg[gi]);
        end
    endgenerate

    // ************************************************************
    // apb slave
    // ************************************************************
    logic        apb_commit;
    logic        apb_wr;
    logic        addr_mapped;
    logic [31:0] read_mux;

    // pready comes one cycle into the access phase so it can be a flop
    assign apb_commit = psel_in & penable_in & pready_out;
    assign apb_wr     = apb_commit & pwrite_in & ~pslverr_out;

    always_comb begin
        read_mux    = 32'h0000_0000;
        addr_mapped = 1'b1;
        if (paddr_in == ppol_pkg::OFS_PORTA_OUTPUT) begin
            read_mux[7:0] = pin_output_bit_reg[7:0];
        end else if (paddr_in == ppol_pkg::OFS_PORTA_DIR) begin
            read_mux[7:0] = pin_direction_bit_reg[7:0];
        end else if (paddr_in == ppol_pkg::OFS_PORTA_INPUT) begin
            read_mux[7:0] = digital_in_reg[7:0];
        end else if (paddr_in == ppol_pkg::OFS_PORTB_OUTPUT) begin
            read_mux[7:0] = pin_output_bit_reg[15:8];
        end else if (paddr_in == ppol_pkg::OFS_PORTB_DIR) begin
            read_mux[7:0] = pin_direction_bit_reg[15:8];
        end else if (paddr_in == ppol_pkg::OFS_PORTB_INPUT) begin
            read_mux[7:0] = digital_in_reg[15:8];
        end else if (paddr_in == ppol_pkg::OFS_PORT_CTRL) begin
            read_mux[ppol_pkg::CTRL_PUD_BIT] = global_pullup_disable_reg;
        end else if (paddr_in == ppol_pkg::OFS_EXT_IRQ_CFG) begin
            read_mux[ppol_pkg::CFG_ENABLE_LO +: 4] = ext_irq_enable_reg;
            read_mux[ppol_pkg::CFG_SENSE_LO +: 8]  = ext_irq_sense_reg;
        end else if (paddr_in == ppol_pkg::OFS_EXT_IRQ_FLAG) begin
            read_mux[3:0] = ext_irq_flag_reg;
        end else begin
            addr_mapped = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out &
                           ~addr_mapped;
            if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
                prdata_out <= read_mux;
            end
        end
    end

    // ************************************************************
    // port data and direction
    // ************************************************************
    logic [15:0] toggle_mask;

    always_comb begin
        toggle_mask = pin_toggle_override_enable_in;
        if (apb_wr && paddr_in == ppol_pkg::OFS_PORTA_INPUT) begin
            toggle_mask[7:0] = toggle_mask[7:0] | pwdata_in[7:0];
        end
        if (apb_wr && paddr_in == ppol_pkg::OFS_PORTB_INPUT) begin
            toggle_mask[15:8] = toggle_mask[15:8] | pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_output_bit_reg <= {2{ppol_pkg::PORT_RESET}};
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_PORTA_OUTPUT) begin
            pin_output_bit_reg <= {pin_output_bit_reg[15:8] ^
                                   toggle_mask[15:8], pwdata_in[7:0]};
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_PORTB_OUTPUT) begin
            pin_output_bit_reg <= {pwdata_in[7:0],
                                   pin_output_bit_reg[7:0] ^
                                   toggle_mask[7:0]};
        end else begin
            pin_output_bit_reg <= pin_output_bit_reg ^ toggle_mask;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_direction_bit_reg <= {2{ppol_pkg::PORT_RESET}};
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_PORTA_DIR) begin
            pin_direction_bit_reg[7:0] <= pwdata_in[7:0];
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_PORTB_DIR) begin
            pin_direction_bit_reg[15:8] <= pwdata_in[7:0];
        end
    end

    // ************************************************************
    // control and external interrupt registers
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            global_pullup_disable_reg <= 1'b0;
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_PORT_CTRL) begin
            global_pullup_disable_reg <= pwdata_in[ppol_pkg::CTRL_PUD_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_irq_enable_reg <= ppol_pkg::IRQ_RESET;
            ext_irq_sense_reg  <= ppol_pkg::SENSE_RESET;
        end else if (apb_wr && paddr_in == ppol_pkg::OFS_EXT_IRQ_CFG) begin
            ext_irq_enable_reg <= pwdata_in[ppol_pkg::CFG_ENABLE_LO +: 4];
            ext_irq_sense_reg  <= pwdata_in[ppol_pkg::CFG_SENSE_LO +: 8];
        end
    end

    // write one to clear; a new edge in the same cycle wins
    logic [3:0] flag_clear;
    logic [3:0] flag_next;
    assign flag_clear = (apb_wr && paddr_in == ppol_pkg::OFS_EXT_IRQ_FLAG) ?
                        pwdata_in[3:0] : 4'h0;
    assign flag_next  = (ext_irq_flag_reg & ~flag_clear) |
                        ext_edge_set;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_irq_flag_reg <= ppol_pkg::IRQ_RESET;
            ext_in_prev_reg  <= 4'h0;
            ext_irq_flag_out <= 4'h0;
        end else begin
            ext_in_prev_reg  <= ext_now;
            ext_irq_flag_reg <= flag_next;
            ext_irq_flag_out <= flag_next;
        end
    end

endmodule : ppol_top

/* shared/ppol_pkg.sv */
package ppol_pkg;

    // ************************************************************
    // pin arrangement: bits 7:0 are port A, bits 15:8 port B
    // ************************************************************
    localparam int PIN_COUNT      = 16;
    localparam int PORT_WIDTH     = 8;
    localparam int PORTB_BASE     = 8;
    localparam int EXT_IRQ_COUNT  = 4;
    localparam int EXT_IRQ_PIN_LO = 4;
    localparam int ANALOG_COUNT   = 5;
    localparam int TEST_PIN_LO    = 8;
    localparam int TEST_PIN_COUNT = 4;
    localparam int OC_A_PIN       = 14;
    localparam int OC_B_PIN       = 15;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_PORTA_OUTPUT = 8'h00;
    localparam logic [7:0] OFS_PORTA_DIR    = 8'h04;
    localparam logic [7:0] OFS_PORTA_INPUT  = 8'h08;
    localparam logic [7:0] OFS_PORTB_OUTPUT = 8'h0C;
    localparam logic [7:0] OFS_PORTB_DIR    = 8'h10;
    localparam logic [7:0] OFS_PORTB_INPUT  = 8'h14;
    localparam logic [7:0] OFS_PORT_CTRL    = 8'h18;
    localparam logic [7:0] OFS_EXT_IRQ_CFG  = 8'h1C;
    localparam logic [7:0] OFS_EXT_IRQ_FLAG = 8'h20;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_PUD_BIT      = 0;
    localparam int CFG_ENABLE_LO     = 0;
    localparam int CFG_SENSE_LO      = 8;
    localparam int CFG_SENSE_WIDTH   = 8;

    localparam logic [7:0] PORT_RESET  = 8'h00;
    localparam logic [3:0] IRQ_RESET   = 4'h0;
    localparam logic [7:0] SENSE_RESET = 8'h00;

    // test port pull-up override values for pins B3..B0
    localparam logic [3:0] TEST_PULLUP_VALUE = 4'hE;

    // ************************************************************
    // external interrupt sense encodings
    // ************************************************************
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_ANY_EDGE  = 2'h1,
        SENSE_FALLING   = 2'h2,
        SENSE_RISING    = 2'h3
    } ppol_sense_t;

endpackage : ppol_pkg

/* tb/ppol_periph_model.sv */
`timescale 1ns/1ns
module ppol_periph_model (
    input  wire logic        clk_in,        // clock
    input  wire logic        rst_b_in,      // reset
    input  wire logic        timer_on_in,   // compare outputs live
    input  wire logic        test_on_in,    // test port live
    input  wire logic [15:0] pin_change_in, // digital inputs
    output logic             cmp_a_out,     // compare a
    output logic             cmp_b_out,     // compare b
    output logic             cmp_en_out,    // compare enables
    output logic             test_en_out,   // test port on
    output logic             tdo_out,       // test data out
    output logic             shift_out,     // shifting
    output logic      [15:0] synced_out     // synchronised inputs
);
    // ************************************************************
    // peripheral activity
    // ************************************************************
    logic [3:0]  count_reg;
    logic [15:0] sync1_reg;
    // inputs arrive unsynchronised, so two flops first
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg  <= 4'h0;
            sync1_reg  <= 16'h0000;
            synced_out <= 16'h0000;
        end else begin
            count_reg  <= count_reg + 4'h1;
            sync1_reg  <= pin_change_in;
            synced_out <= sync1_reg;
        end
    end
    // value only; direction is left to software
    assign cmp_a_out   = count_reg[0];
    assign cmp_b_out   = count_reg[1];
    assign cmp_en_out  = timer_on_in;
    assign test_en_out = test_on_in;
    assign tdo_out     = count_reg[0] ^ count_reg[2];
    assign shift_out   = count_reg[3];
endmodule : ppol_periph_model

/* tb/ppol_top_sva.sv */
`timescale 1ns/1ns
module ppol_top_sva (
    input wire logic        clk_in,                       // clock
    input wire logic        rst_b_in,                     // reset
    input wire logic [15:0] pad_in,                       // pads
    input wire logic [15:0] pad_out,                      // level
    input wire logic [15:0] pad_oe_out,                   // drive
    input wire logic [15:0] pad_pullup_out,               // pull-up
    input wire logic        sleep_clamp_in,               // clamp
    input wire logic        timer0_compare_out_a_in,      // cmp a
    input wire logic        timer0_compare_a_en_in,       // cmp a on
    input wire logic        timer0_compare_out_b_in,      // cmp b
    input wire logic        timer0_compare_b_en_in,       // cmp b on
    input wire logic        test_port_enabled_in,         // test on
    input wire logic        test_data_out_in,             // tdo
    input wire logic        test_shift_in,                // shift
    input wire logic [15:0] pin_change_irq_sources_out,   // pin change
    input wire logic [4:0]  alt_function_analog_path_out, // analog
    input wire logic [2:0]  test_port_in_out              // tap in
);
    // ************************************************************
    // pin override properties
    // ************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    a_clamp_low_pins: assert property ($past(sleep_clamp_in) |->
        pin_change_irq_sources_out[3:0] == 4'h0 &&
        pin_change_irq_sources_out[13:12] == 2'h0)
        else $error("clamped pin reached pin change");
    a_pc_follows_pad: assert property (
        !$past(sleep_clamp_in) && !$past(test_port_enabled_in) |->
        pin_change_irq_sources_out == $past(pad_in))
        else $error("pin change differs from pads");
    a_analog_raw: assert property (
        alt_function_analog_path_out == $past(pad_in[4:0]))
        else $error("analog path differs from pads");
    a_tap_inputs_raw: assert property (
        test_port_in_out == $past(pad_in[11:9]))
        else $error("test inputs differ from pads");
    a_test_takes_pins: assert property (
        $past(test_port_enabled_in) |->
        pad_pullup_out[11:8] == ppol_pkg::TEST_PULLUP_VALUE &&
        pad_oe_out[11:9] == 3'h0 && pin_change_irq_sources_out[11:8] == 4'h0)
        else $error("test port pins not taken over");
    a_tdo_drive: assert property ($past(test_port_enabled_in) |->
        pad_oe_out[8] == $past(test_shift_in) &&
        pad_out[8] == $past(test_data_out_in))
        else $error("test data out pin wrong");
    a_cmp_a_value: assert property (
        $past(timer0_compare_a_en_in) |->
        pad_out[14] == $past(timer0_compare_out_a_in))
        else $error("compare a level wrong");
    a_cmp_b_value: assert property (
        $past(timer0_compare_b_en_in) |->
        pad_out[15] == $past(timer0_compare_out_b_in))
        else $error("compare b level wrong");
endmodule : ppol_top_sva

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    logic        clk_in, rst_b_in, psel_in, penable_in, pwrite_in;
    logic        sleep_clamp_in, timer_on, test_on, pslverr_out, pready_out;
    logic        timer0_compare_out_a_in, timer0_compare_out_b_in, cmp_en;
    logic        test_port_enabled_in, test_data_out_in, test_shift_in, err;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [15:0] pad_ext, pad_out, pad_oe_out, pad_pullup_out, pc;
    logic [15:0] pin_toggle_override_enable_in;
    logic [3:0]  external_irq_inputs_out, ext_irq_flag_out;
    logic [4:0]  alt_function_analog_path_out;
    logic [2:0]  test_port_in_out;
    wire  [15:0] pad_in = (pad_oe_out & pad_out) | (~pad_oe_out & pad_ext);
    int          errors, check_count;
    ppol_top u_dut (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .pad_in, .pad_out, .pad_oe_out, .pad_pullup_out, .sleep_clamp_in,
        .pin_toggle_override_enable_in, .timer0_compare_out_a_in,
        .timer0_compare_a_en_in(cmp_en), .timer0_compare_out_b_in,
        .timer0_compare_b_en_in(cmp_en), .test_port_enabled_in,
        .test_data_out_in, .test_shift_in, .pin_change_irq_sources_out(pc),
        .external_irq_inputs_out, .ext_irq_flag_out,
        .alt_function_analog_path_out, .test_port_in_out);
    ppol_periph_model u_periph (.clk_in, .rst_b_in, .timer_on_in(timer_on),
        .test_on_in(test_on), .pin_change_in(pc),
        .cmp_a_out(timer0_compare_out_a_in), .cmp_en_out(cmp_en),
        .cmp_b_out(timer0_compare_out_b_in), .shift_out(test_shift_in),
        .test_en_out(test_port_enabled_in), .tdo_out(test_data_out_in),
        .synced_out());
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic test_done;
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_in);
        {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            errors++;
            test_done();
        end
        err = pslverr_out;
        @(posedge clk_in);
        rd = prdata_out;
        {psel_in, penable_in} <= 2'b00;
    endtask : apb
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #10;
    endtask : settle
    initial begin
        {rst_b_in, psel_in, penable_in, pwrite_in, sleep_clamp_in} = 5'h00;
        {timer_on, test_on, paddr_in, pwdata_in, pad_ext} = 58'h0;
        pin_toggle_override_enable_in = 16'h0000;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            check(rd | pad_oe_out | pad_pullup_out | pad_out, 0);
        end
        apb(1'b1, ppol_pkg::OFS_PORTA_OUTPUT, 32'hFF);
        apb(1'b1, ppol_pkg::OFS_PORTA_DIR, 32'h0F);
        settle;
        check({pad_pullup_out[7:0], pad_oe_out[7:0], pad_out[3:0]}, 20'hF00FF);
        apb(1'b1, ppol_pkg::OFS_PORT_CTRL, 32'h1);
        settle;
        check(pad_pullup_out[7:0], 0);
        apb(1'b1, ppol_pkg::OFS_PORT_CTRL, 32'h0);
        @(posedge clk_in) pin_toggle_override_enable_in <= 16'h0021;
        @(posedge clk_in) pin_toggle_override_enable_in <= 16'h0000;
        apb(1'b0, ppol_pkg::OFS_PORTA_OUTPUT, 32'h0);
        check({rd[7:0], pad_out[3:0]}, 12'hDEE);
        apb(1'b1, ppol_pkg::OFS_PORTB_DIR, 32'h40);
        @(posedge clk_in) timer_on <= 1'b1;
        settle;
        check(pad_oe_out[15:14], 2'b01);
        apb(1'b1, ppol_pkg::OFS_PORTB_DIR, 32'hFF);
        @(posedge clk_in) {test_on, pad_ext} <= {1'b1, 16'h0E00};
        settle;
        check({pad_pullup_out[11:8], pc[11:8], test_port_in_out}, 11'h707);
        @(posedge clk_in) {test_on, pad_ext} <= {1'b0, 16'h00F5};
        apb(1'b1, ppol_pkg::OFS_EXT_IRQ_CFG, 32'h0C01);
        apb(1'b1, ppol_pkg::OFS_EXT_IRQ_FLAG, 32'hF);
        @(posedge clk_in) sleep_clamp_in <= 1'b1;
        settle;
        check({external_irq_inputs_out, pc[7:0], ext_irq_flag_out}, 16'h1100);
        @(posedge clk_in) sleep_clamp_in <= 1'b0;
        apb(1'b0, ppol_pkg::OFS_EXT_IRQ_FLAG, 32'h0);
        check({rd[3:0], pc[7:0], ext_irq_flag_out}, 16'h2FE2);
        apb(1'b0, 8'h40, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        test_done();
    end
endmodule : testbench
bind ppol_top ppol_top_sva u_sva (.*);
